// ==== core/rgc_core.sv ====
// Chosen here: the APB slave port.
module rgc_core
  import rgc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] converter_pin,
  input wire logic receive_state,
  input wire logic idle_ready_state,
  input wire logic packet_mode,
  input wire logic preamble_detected,
  input wire logic postamble_active,
  input wire logic packet_valid,
  input wire logic measure_level_command,
  output logic [1:0] lna_gain,
  output logic mixer_gain_low,
  output logic [1:0] filter_gain,
  output logic [7:0] image_phase_trim,
  output logic [7:0] image_amplitude_trim,
  output logic measure_busy
);
  // ****************************************
  // Functions
  // ****************************************
  // Stage to {lna, mixer, filter}
  function automatic logic [4:0] stage_gains(input logic [2:0] st);
    logic [4:0] g;
    g = {G_LOW, 1'b1, G_LOW};
    case (st)
      3'h0: g = {G_HIGH, 1'b0, G_HIGH};
      3'h1: g = {G_HIGH, 1'b1, G_HIGH};
      3'h2: g = {G_MED, 1'b1, G_HIGH};
      3'h3: g = {G_LOW, 1'b1, G_HIGH};
      3'h4: g = {G_LOW, 1'b1, G_MED};
      default: g = {G_LOW, 1'b1, G_LOW};
    endcase
    return g;
  endfunction : stage_gains
  // Gains to report code; odd manual mixes show raw fields
  function automatic logic [7:0] report_code(input logic [4:0] g);
    logic [7:0] c;
    c = {3'h4, g};
    case (g)
      {G_HIGH, 1'b0, G_HIGH}: c = 8'h00;
      {G_HIGH, 1'b1, G_HIGH}: c = 8'h01;
      {G_MED, 1'b1, G_HIGH}: c = 8'h02;
      {G_LOW, 1'b1, G_HIGH}: c = 8'h0a;
      {G_LOW, 1'b1, G_MED}: c = 8'h12;
      {G_LOW, 1'b1, G_LOW}: c = 8'h16;
      default: c = {3'h4, g};
    endcase
    return c;
  endfunction : report_code
  // Level code to signed result
  function automatic logic [7:0] to_result(input logic [7:0] lvl);
    return {1'b0, lvl[7:1]} - RESULT_BIAS;
  endfunction : to_result

  // ****************************************
  // Converter synchroniser; word kept only when two copies agree
  // ****************************************
  logic [7:0] conv_meta_reg;
  logic [7:0] conv_sync_reg;
  logic [7:0] conv_hold_reg;
  logic [7:0] conv_val_reg;
  logic [7:0] level_filt;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_meta_reg <= 8'h00;
      conv_sync_reg <= 8'h00;
      conv_hold_reg <= 8'h00;
      conv_val_reg <= 8'h00;
    end else begin
      conv_meta_reg <= converter_pin;
      conv_sync_reg <= conv_meta_reg;
      conv_hold_reg <= conv_sync_reg;
      if (conv_sync_reg == conv_hold_reg) conv_val_reg <= conv_sync_reg;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  logic [7:0] policy_cfg_reg;
  logic [7:0] dwell_div_reg;
  logic [7:0] override_reg;
  logic [7:0] raise_lvl_reg;
  logic [7:0] reduce_lvl_reg;
  logic [7:0] phase_trim_reg;
  logic [7:0] ampl_trim_reg;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [4:0] applied_reg;
  logic [4:0] applied_next;
  logic [31:0] prdata_reg;
  logic [7:0] rd_byte;
  logic [9:0] idx;
  logic hit;
  logic wr_en;
  assign idx = paddr[11:2];
  assign hit = (paddr[1:0] == 2'h0) &&
               (idx == IDX_POLICY_CFG || idx == IDX_PHASE_TRIM ||
                idx == IDX_AMPL_TRIM || idx == IDX_LEVEL_RESULT ||
                idx == IDX_SAMPLE_A || idx == IDX_SAMPLE_B ||
                idx == IDX_DWELL_DIV || idx == IDX_OVERRIDE ||
                idx == IDX_RAISE_LVL || idx == IDX_REDUCE_LVL ||
                idx == IDX_STAGE_REPORT);
  // No wait states; the answer comes in the first access cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite & hit;
  assign prdata = prdata_reg;
  assign rd_byte = (idx == IDX_POLICY_CFG) ? policy_cfg_reg :
                   (idx == IDX_PHASE_TRIM) ? phase_trim_reg :
                   (idx == IDX_AMPL_TRIM) ? ampl_trim_reg :
                   (idx == IDX_LEVEL_RESULT) ? result_reg :
                   (idx == IDX_SAMPLE_A) ? conv_val_reg :
                   (idx == IDX_SAMPLE_B) ? level_filt :
                   (idx == IDX_DWELL_DIV) ? dwell_div_reg :
                   (idx == IDX_OVERRIDE) ? override_reg :
                   (idx == IDX_RAISE_LVL) ? raise_lvl_reg :
                   (idx == IDX_REDUCE_LVL) ? reduce_lvl_reg :
                   (idx == IDX_STAGE_REPORT) ? report_code(applied_reg) :
                   8'h00;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_reg <= {24'h000000, rd_byte};
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      policy_cfg_reg <= RST_POLICY_CFG;
      dwell_div_reg <= RST_DWELL_DIV;
      override_reg <= RST_OVERRIDE;
      raise_lvl_reg <= RST_RAISE_LVL;
      reduce_lvl_reg <= RST_REDUCE_LVL;
      phase_trim_reg <= RST_TRIM;
      ampl_trim_reg <= RST_TRIM;
    end else if (wr_en) begin
      if (idx == IDX_POLICY_CFG) policy_cfg_reg <= pwdata[7:0];
      if (idx == IDX_DWELL_DIV) dwell_div_reg <= pwdata[7:0];
      if (idx == IDX_OVERRIDE) override_reg <= pwdata[7:0];
      if (idx == IDX_RAISE_LVL) raise_lvl_reg <= pwdata[7:0];
      if (idx == IDX_REDUCE_LVL) reduce_lvl_reg <= pwdata[7:0];
      if (idx == IDX_PHASE_TRIM) phase_trim_reg <= pwdata[7:0];
      if (idx == IDX_AMPL_TRIM) ampl_trim_reg <= pwdata[7:0];
    end
  end
  assign image_phase_trim = phase_trim_reg;
  assign image_amplitude_trim = ampl_trim_reg;

  // ****************************************
  // Gain loop
  // ****************************************
  rgc_state_t state_reg;
  rgc_state_t state_next;
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic [15:0] dwell_cnt_reg;
  logic [15:0] dwell_limit;
  logic [18:0] dwell_prod;
  logic [1:0] policy;
  logic hold_bit;
  logic dwell_done;
  logic may_step;
  logic go_down;
  logic go_up;
  logic [4:0] manual_gains;
  assign policy = policy_cfg_reg[1:0];
  assign hold_bit = override_reg[OVR_HOLD_BIT];
  assign dwell_prod = 19'(dwell_div_reg) * 19'(DWELL_DEFAULT_CYCLES)
                      / 19'(RST_DWELL_DIV);
  assign dwell_limit = (dwell_prod == 19'h0) ? 16'h0001 : dwell_prod[15:0];
  assign dwell_done = (dwell_cnt_reg + 16'h0001 >= dwell_limit);
  // steps only when free to move
  assign may_step = (state_reg == RGC_RUN) && dwell_done && !hold_bit &&
                    (policy == POL_FREE || policy == POL_LOCK);
  assign go_down = may_step && (conv_val_reg > reduce_lvl_reg) &&
                   (stage_reg != STAGE_BOTTOM);
  assign go_up = may_step && (conv_val_reg < raise_lvl_reg) &&
                 (stage_reg != STAGE_TOP) && !go_down;
  assign stage_next = go_down ? stage_reg + 3'h1 :
                      go_up ? stage_reg - 3'h1 : stage_reg;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RGC_IDLE: if (receive_state) state_next = RGC_RUN;
      RGC_RUN: begin
        if (!receive_state) state_next = RGC_IDLE;
        else if (policy == POL_LOCK && preamble_detected)
          state_next = RGC_LOCKED;
      end
      RGC_LOCKED: if (!receive_state) state_next = RGC_IDLE;
      default: state_next = RGC_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= RGC_IDLE;
      stage_reg <= STAGE_TOP;
      dwell_cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      stage_reg <= stage_next;
      dwell_cnt_reg <= (dwell_done || state_reg != RGC_RUN) ? 16'h0000
                       : dwell_cnt_reg + 16'h0001;
    end
  end
  assign manual_gains = {override_reg[OVR_LNA_LSB +: 2],
                         override_reg[OVR_MIX_BIT],
                         override_reg[OVR_FILT_LSB +: 2]};
  assign applied_next = (policy == POL_MANUAL) ? manual_gains
                                               : stage_gains(stage_reg);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      applied_reg <= {G_HIGH, 1'b0, G_HIGH};
    end else begin
      applied_reg <= applied_next;
    end
  end
  assign lna_gain = applied_reg[4:3];
  assign mixer_gain_low = applied_reg[2];
  assign filter_gain = applied_reg[1:0];

  // ****************************************
  // Level measurement
  // ****************************************
  logic [7:0] post_lvl_reg;
  logic [15:0] meas_cnt_reg;
  logic meas_start;
  logic meas_done;
  logic post_load;
  assign meas_start = measure_level_command && idle_ready_state &&
                      (meas_cnt_reg == 16'h0000);
  assign meas_done = (meas_cnt_reg == 16'h0001);
  assign measure_busy = (meas_cnt_reg != 16'h0000);
  // postamble path only in packet mode
  assign post_load = packet_valid && packet_mode;
  rgc_lvl_filter u_filt (
    .core_clk(core_clk),
    .reset(reset),
    .preset_en(meas_start),
    .sample(conv_val_reg),
    .level_filt(level_filt)
  );
  // postamble level kept for the packet end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      post_lvl_reg <= 8'h00;
      meas_cnt_reg <= 16'h0000;
    end else begin
      if (postamble_active && packet_mode) post_lvl_reg <= conv_val_reg;
      if (meas_start) meas_cnt_reg <= MEASURE_CYCLES;
      else if (measure_busy) meas_cnt_reg <= meas_cnt_reg - 16'h0001;
    end
  end
  assign result_next = meas_done ? to_result(level_filt) :
                       post_load ? to_result(post_lvl_reg) : result_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      result_reg <= 8'h00;
    end else begin
      result_reg <= result_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_DWELL_RESET: assert property (@(posedge core_clk)
    $fell(reset) |-> dwell_div_reg == RST_DWELL_DIV && dwell_limit == 16'h04e2)
    else $error("Dwell divider reset value wrong");
  AST_ONE_STEP: assert property (@(posedge core_clk) disable iff (reset)
    stage_reg != $past(stage_reg) |-> $past(dwell_done) &&
    (stage_reg == $past(stage_reg) + 3'h1 ||
     stage_reg == $past(stage_reg) - 3'h1))
    else $error("Stage moved outside a dwell boundary");
  AST_REDUCE: assert property (@(posedge core_clk) disable iff (reset)
    may_step && conv_val_reg > reduce_lvl_reg && stage_reg < 3'h5
    |=> stage_reg == $past(stage_reg) + 3'h1)
    else $error("Gain not reduced");
  AST_RAISE: assert property (@(posedge core_clk) disable iff (reset)
    may_step && conv_val_reg < raise_lvl_reg &&
    conv_val_reg <= reduce_lvl_reg && stage_reg > 3'h0
    |=> stage_reg == $past(stage_reg) - 3'h1)
    else $error("Gain not raised");
  AST_FROZEN: assert property (@(posedge core_clk) disable iff (reset)
    (policy == POL_HOLD || hold_bit || state_reg == RGC_LOCKED)
    |=> $stable(stage_reg))
    else $error("Stage changed while frozen");
  AST_MANUAL: assert property (@(posedge core_clk) disable iff (reset)
    policy == POL_MANUAL ##1 policy == POL_MANUAL
    |-> lna_gain == $past(override_reg[1:0]) &&
        filter_gain == $past(override_reg[4:3]))
    else $error("Manual gains not applied");
  AST_REPORT: assert property (@(posedge core_clk) disable iff (reset)
    psel && !penable && idx == IDX_STAGE_REPORT
    |=> prdata[7:0] == report_code($past(applied_reg)))
    else $error("Report read wrong");
  AST_POSTAMBLE: assert property (@(posedge core_clk) disable iff (reset)
    post_load && !meas_done
    |=> result_reg == {1'b0, $past(post_lvl_reg[7:1])})
    else $error("Postamble level not loaded");
  AST_NO_SERIAL: assert property (@(posedge core_clk) disable iff (reset)
    packet_valid && !packet_mode && !meas_done |=> $stable(result_reg))
    else $error("Result loaded outside packet mode");
  AST_MEASURE: assert property (@(posedge core_clk) disable iff (reset)
    meas_start |=> measure_busy [*8] ##[1:60] meas_done)
    else $error("Measurement did not finish in time");
  AST_IDLE_ONLY: assert property (@(posedge core_clk) disable iff (reset)
    !idle_ready_state && !measure_busy |=> !measure_busy)
    else $error("Measurement started outside idle-ready");
  COV_DOWN: cover property (@(posedge core_clk) go_down);
  COV_UP: cover property (@(posedge core_clk) go_up);
  COV_LOCK: cover property (@(posedge core_clk) state_reg == RGC_LOCKED);
  COV_MEAS: cover property (@(posedge core_clk) meas_done);
endmodule : rgc_core

// ==== core/rgc_pkg.sv ====
package rgc_pkg;
  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [9:0] IDX_POLICY_CFG = 10'h113;
  localparam logic [9:0] IDX_PHASE_TRIM = 10'h118;
  localparam logic [9:0] IDX_AMPL_TRIM = 10'h119;
  localparam logic [9:0] IDX_LEVEL_RESULT = 10'h312;
  localparam logic [9:0] IDX_SAMPLE_A = 10'h327;
  localparam logic [9:0] IDX_SAMPLE_B = 10'h328;
  localparam logic [9:0] IDX_DWELL_DIV = 10'h32f;
  localparam logic [9:0] IDX_OVERRIDE = 10'h35d;
  localparam logic [9:0] IDX_RAISE_LVL = 10'h35e;
  localparam logic [9:0] IDX_REDUCE_LVL = 10'h35f;
  localparam logic [9:0] IDX_STAGE_REPORT = 10'h360;
  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [7:0] RST_DWELL_DIV = 8'h28;
  localparam logic [7:0] RST_POLICY_CFG = 8'h00;
  localparam logic [7:0] RST_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_RAISE_LVL = 8'h40;
  localparam logic [7:0] RST_REDUCE_LVL = 8'hc0;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam int OVR_HOLD_BIT = 6;
  localparam int OVR_LNA_LSB = 0;
  localparam int OVR_MIX_BIT = 2;
  localparam int OVR_FILT_LSB = 3;
  localparam logic [1:0] POL_FREE = 2'h0;
  localparam logic [1:0] POL_MANUAL = 2'h1;
  localparam logic [1:0] POL_HOLD = 2'h2;
  localparam logic [1:0] POL_LOCK = 2'h3;
  localparam logic [2:0] STAGE_TOP = 3'h0;
  localparam logic [2:0] STAGE_BOTTOM = 3'h5;
  // Gain levels: 0 high, 1 medium, 2 low
  localparam logic [1:0] G_HIGH = 2'h0;
  localparam logic [1:0] G_MED = 2'h1;
  localparam logic [1:0] G_LOW = 2'h2;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int DWELL_DEFAULT_NS = 25000;
  localparam int DWELL_DEFAULT_CYCLES = DWELL_DEFAULT_NS / CLK_PERIOD_NS;
  localparam logic [15:0] MEASURE_CYCLES = 16'h0040;
  localparam logic [7:0] RESULT_BIAS = 8'h00;
  typedef enum logic [1:0] {
    RGC_IDLE = 2'b00,
    RGC_RUN = 2'b01,
    RGC_LOCKED = 2'b11
  } rgc_state_t;
endpackage : rgc_pkg

// ==== core/rgc_lvl_filter.sv ====
module rgc_lvl_filter
  import rgc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic preset_en,
  input wire logic [7:0] sample,
  output logic [7:0] level_filt
);
  // ****************************************
  // Low-pass, one-eighth step
  // ****************************************
  logic [10:0] acc_reg;
  logic [10:0] acc_next;
  // Preset avoids a slow climb from zero at the start of a measurement
  assign acc_next = preset_en ? {sample, 3'h0}
                              : acc_reg - {3'h0, acc_reg[10:3]} + {3'h0, sample};
  always_ff @(posedge core_clk) begin
    if (reset) begin
      acc_reg <= 11'h000;
    end else begin
      acc_reg <= acc_next;
    end
  end
  assign level_filt = acc_reg[10:3];
endmodule : rgc_lvl_filter

// ==== sim/rgc_front_model.sv ====
// ****************************************
// Analogue front end stand-in
// ****************************************
module rgc_front_model #(
  parameter int POST_LEN = 8
) (
  input wire logic core_clk,
  input wire logic [7:0] level,
  input wire logic pkt_go,
  input wire logic pre_go,
  output logic [7:0] converter_pin,
  output logic preamble_detected,
  output logic postamble_active,
  output logic packet_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always @(posedge core_clk) begin
    converter_pin <= level;
    preamble_detected <= pre_go;
  end
  // postamble then valid packet
  // Valid pulse only after postamble ends, as a real receiver would
  always @(posedge core_clk) begin
    packet_valid <= (cnt == 1);
    postamble_active <= pkt_go || (cnt > 1);
    if (pkt_go) begin
      cnt <= POST_LEN;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : rgc_front_model

// ==== sim/testbench.sv ====
module testbench
  import rgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, mixer_gain_low, measure_busy;
  logic [7:0] converter_pin, level = 8'h80, lv, eq[$];
  logic receive_state = 0, idle_ready_state = 0, packet_mode = 1;
  logic preamble_detected, postamble_active, packet_valid;
  logic measure_level_command = 0, pkt_go = 0, pre_go = 0, erq[$];
  logic [1:0] lna_gain, filter_gain;
  logic [7:0] image_phase_trim, image_amplitude_trim;
  logic [4:0] g;
  logic [7:0] rd_last, rpt;
  wire [4:0] gv = {lna_gain, mixer_gain_low, filter_gain};
  int err_count = 0, n_tests = 0, n, s;
  // Gain table as {lna, mixer low, filter}, then report codes
  logic [4:0] gt[6] = '{5'h00, 5'h04, 5'h0c, 5'h14, 5'h15, 5'h16};
  logic [7:0] rc[6] = '{8'h00, 8'h01, 8'h02, 8'h0a, 8'h12, 8'h16};
  always #10 core_clk = ~core_clk;
  rgc_core rgc_core_i (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .converter_pin(converter_pin), .receive_state(receive_state),
    .idle_ready_state(idle_ready_state), .packet_mode(packet_mode),
    .preamble_detected(preamble_detected),
    .postamble_active(postamble_active), .packet_valid(packet_valid),
    .measure_level_command(measure_level_command), .lna_gain(lna_gain),
    .mixer_gain_low(mixer_gain_low), .filter_gain(filter_gain),
    .image_phase_trim(image_phase_trim),
    .image_amplitude_trim(image_amplitude_trim),
    .measure_busy(measure_busy));
  rgc_front_model rgc_front_model_i (.core_clk(core_clk), .level(level),
    .pkt_go(pkt_go), .pre_go(pre_go), .converter_pin(converter_pin),
    .preamble_detected(preamble_detected),
    .postamble_active(postamble_active), .packet_valid(packet_valid));
  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction : ad
  // host offset table, host level formula
  function automatic int host_dbm(input logic [7:0] cd,
                                  input logic [7:0] smp);
    int off;
    case (cd)
      8'h00: off = 44;
      8'h01: off = 35;
      8'h02: off = 26;
      8'h0a: off = 17;
      8'h12: off = 10;
      8'h16: off = 0;
      default: off = 0;
    endcase
    return int'(smp) / 7 + off - 109;
  endfunction : host_dbm
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] e);
    n_tests++;
    if (x !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, input logic [7:0] e,
                     input logic er);
    if (!w) begin
      eq.push_back(e);
      erq.push_back(er);
    end
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    apb(1'b1, ad(i), d, 8'h00, 1'b0);
  endtask : wr
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    apb(1'b0, ad(i), 8'h00, e, 1'b0);
  endtask : rd
  task automatic wchg;
    g = gv;
    n = 0;
    while (gv === g && n < 200) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wchg
  task automatic still(input int c);
    g = gv;
    repeat (c) @(posedge core_clk);
    chk("gain steady", 32'(gv), 32'(g));
  endtask : still
  task automatic gains(input int k);
    chk("gain outputs", 32'(gv), 32'(gt[k]));
    rd(IDX_STAGE_REPORT, rc[k]);
  endtask : gains
  task automatic meas;
    measure_level_command <= 1'b1;
    @(posedge core_clk);
    measure_level_command <= 1'b0;
    n = 0;
    repeat (100) begin
      @(posedge core_clk);
      if (measure_busy === 1'b1) n++;
    end
  endtask : meas
  task automatic pulse_pkt;
    pkt_go <= 1'b1;
    @(posedge core_clk);
    pkt_go <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask : pulse_pkt
  task automatic do_reset;
    reset <= 1'b1;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
  endtask : do_reset
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // ****************************************
  // Read monitor, oldest note first
  // ****************************************
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", prdata, {24'h0, eq.pop_front()});
      chk("pslverr", 32'(pslverr), 32'(erq.pop_front()));
      rd_last = prdata[7:0];
    end
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    end_sim();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'hd57d0f73));
    do_reset();
    rd(IDX_DWELL_DIV, 8'h28);
    rd(IDX_POLICY_CFG, 8'h00);
    rd(IDX_OVERRIDE, 8'h00);
    rd(IDX_RAISE_LVL, RST_RAISE_LVL);
    rd(IDX_REDUCE_LVL, RST_REDUCE_LVL);
    gains(0);
    apb(1'b0, 12'h000, 8'h00, 8'h00, 1'b1);
    apb(1'b0, ad(IDX_SAMPLE_A) + 12'h001, 8'h00, level, 1'b1);
    wr(IDX_STAGE_REPORT, 8'h16);
    rd(IDX_STAGE_REPORT, 8'h00);
    wr(IDX_AMPL_TRIM, 8'h07);
    wr(IDX_PHASE_TRIM, 8'h16);
    chk("amplitude trim", 32'(image_amplitude_trim), 32'h07);
    chk("phase trim", 32'(image_phase_trim), 32'h16);
    lv = 8'($urandom_range(8'hbd, 8'h41));
    level <= lv;
    repeat (5) @(posedge core_clk);
    rd(IDX_SAMPLE_A, lv);
    wr(IDX_DWELL_DIV, 8'h01);
    level <= 8'hff;
    receive_state <= 1'b1;
    for (s = 1; s < 6; s++) begin
      wchg();
      gains(s);
    end
    still(150);
    level <= 8'h00;
    for (s = 4; s >= 0; s--) begin
      wchg();
      gains(s);
    end
    still(150);
    wr(IDX_OVERRIDE, 8'h40);
    level <= 8'hff;
    still(150);
    rd(IDX_STAGE_REPORT, 8'h00);
    rpt = rd_last;
    rd(IDX_SAMPLE_A, 8'hff);
    chk("host dbm", 32'(host_dbm(rpt, rd_last)), 32'(-29));
    wr(IDX_OVERRIDE, 8'h00);
    wchg();
    gains(1);
    wr(IDX_POLICY_CFG, 8'h02);
    still(150);
    level <= 8'h80;
    wr(IDX_OVERRIDE, 8'h11);
    wr(IDX_POLICY_CFG, 8'h01);
    repeat (3) @(posedge core_clk);
    chk("manual gains", 32'(gv), 32'h0a);
    wr(IDX_OVERRIDE, 8'h00);
    wr(IDX_POLICY_CFG, 8'h03);
    repeat (3) @(posedge core_clk);
    level <= 8'hff;
    wchg();
    gains(2);
    chk("runs before lock", 32'(n < 200), 32'h1);
    pre_go <= 1'b1;
    @(posedge core_clk);
    pre_go <= 1'b0;
    repeat (5) @(posedge core_clk);
    still(150);
    receive_state <= 1'b0;
    do_reset();
    idle_ready_state <= 1'b1;
    level <= lv;
    repeat (5) @(posedge core_clk);
    meas();
    chk("busy cycles", 32'(n), 32'(MEASURE_CYCLES));
    rd(IDX_LEVEL_RESULT, 8'((lv >> 1) - RESULT_BIAS));
    idle_ready_state <= 1'b0;
    meas();
    chk("refused busy", 32'(n), 32'h0);
    lv = 8'($urandom_range(8'hbd, 8'h41));
    level <= lv;
    receive_state <= 1'b1;
    repeat (5) @(posedge core_clk);
    pulse_pkt();
    rd(IDX_LEVEL_RESULT, 8'((lv >> 1) - RESULT_BIAS));
    packet_mode <= 1'b0;
    level <= lv + 8'h02;
    repeat (5) @(posedge core_clk);
    pulse_pkt();
    rd(IDX_LEVEL_RESULT, 8'((lv >> 1) - RESULT_BIAS));
    end_sim();
  end
endmodule : testbench
